/* File: core/iacm_matcher.sv */
`timescale 1ns/1ps
`default_nettype none
`include "iacm_cfg.svh"

module iacm_matcher
  import iacm_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // register port
  input wire logic [`IACM_ADDR_W-1:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdata,
  // parsed header fields
  input wire logic frameValid,
  input wire logic frameIsIpv6,
  input wire logic [7:0] frameNextHdr,
  input wire logic [31:0] frameSrcLow,
  input wire logic [7:0] frameHopLimit,
  input wire logic [7:0] frameIcmpType,
  input wire logic [7:0] frameIcmpCode,
  // match result
  output logic matchValid,
  output logic matchHit
);

  // ********************************************
  // state
  // ********************************************
  iacm_state_t state_reg;
  iacm_state_t state_next;

  logic isIcmp;
  logic nhCmpHit;
  logic nhHit;
  logic srcHit;
  logic hopHit;
  logic typeHit;
  logic codeHit;
  logic icmpGate;
  logic entryHit;

  // clear always applies; an event in the same cycle is counted on top of the cleared value
  function automatic logic [`IACM_CNT_W-1:0] bumpCount(
    input logic [`IACM_CNT_W-1:0] cnt,
    input logic inc,
    input logic clr
  );
    logic [`IACM_CNT_W-1:0] base;
    base = clr ? `IACM_CNT_RST : cnt;
    // saturate so software sees a pinned value, not a wrap
    if (inc && (base != {`IACM_CNT_W{1'b1}})) begin
      return base + `IACM_CNT_W'(1);
    end
    return base;
  endfunction

  // ********************************************
  // criteria compare
  // ********************************************
  assign isIcmp = (frameNextHdr == `IACM_PROTO_ICMP6);

  iacm_field_cmp #(.W(8)) nhCmp (
    .care(state_reg.nhMode == NH_SPECIFIC),
    .value(state_reg.nhValue),
    .mask(8'hff),
    .field(frameNextHdr),
    .hit(nhCmpHit)
  );

  // low 32 bits only; upper address bits never take part
  iacm_field_cmp #(.W(32)) srcCmp (
    .care(state_reg.srcCare),
    .value(state_reg.srcAddr),
    .mask(state_reg.srcMask),
    .field(frameSrcLow),
    .hit(srcHit)
  );

  iacm_field_cmp #(.W(8)) typeCmp (
    .care(state_reg.typeCare),
    .value(state_reg.typeValue),
    .mask(8'hff),
    .field(frameIcmpType),
    .hit(typeHit)
  );

  iacm_field_cmp #(.W(8)) codeCmp (
    .care(state_reg.codeCare),
    .value(state_reg.codeValue),
    .mask(8'hff),
    .field(frameIcmpCode),
    .hit(codeHit)
  );

  always_comb begin
    case (state_reg.nhMode)
      NH_ANY: nhHit = 1'b1;
      NH_SPECIFIC: nhHit = nhCmpHit;
      NH_ICMP: nhHit = isIcmp;
      NH_UDP: nhHit = (frameNextHdr == `IACM_PROTO_UDP);
      NH_TCP: nhHit = (frameNextHdr == `IACM_PROTO_TCP);
      default: nhHit = 1'b0;
    endcase
  end

  always_comb begin
    case (state_reg.hopMode)
      HOP_ANY: hopHit = 1'b1;
      HOP_ZERO: hopHit = (frameHopLimit == 8'h00);
      HOP_NONZERO: hopHit = (frameHopLimit != 8'h00);
      default: hopHit = 1'b0;
    endcase
  end

  // icmp fields of a non-icmp frame are meaningless
  assign icmpGate = !(state_reg.typeCare || state_reg.codeCare)
                    || isIcmp;

  assign entryHit = state_reg.entryEn && frameIsIpv6 && nhHit
                    && srcHit && hopHit && typeHit && codeHit
                    && icmpGate;

  // ********************************************
  // next state
  // ********************************************
  always_comb begin
    state_next = state_reg;
    state_next.rdata = `IACM_WORD_RST;
    state_next.matchValid = frameValid;
    state_next.matchHit = frameValid && entryHit;
    if (frameValid) begin
      state_next.lastHit = entryHit;
      state_next.seenFrame = 1'b1;
    end
    state_next.hitCount = bumpCount(state_reg.hitCount,
      frameValid && entryHit,
      regWrite && (regAddr == `IACM_OFS_HITCNT));
    state_next.frameCount = bumpCount(state_reg.frameCount,
      frameValid,
      regWrite && (regAddr == `IACM_OFS_FRMCNT));
    if (regWrite) begin
      case (regAddr)
        `IACM_OFS_CTRL: begin
          state_next.nhMode = iacm_nh_mode_t'(
            regWdata[`IACM_CTRL_NH_MSB:`IACM_CTRL_NH_LSB]);
          state_next.srcCare = regWdata[`IACM_CTRL_SRC_BIT];
          state_next.hopMode = iacm_hop_mode_t'(
            regWdata[`IACM_CTRL_HOP_MSB:`IACM_CTRL_HOP_LSB]);
          state_next.typeCare = regWdata[`IACM_CTRL_TYPE_BIT];
          state_next.codeCare = regWdata[`IACM_CTRL_CODE_BIT];
          state_next.entryEn = regWdata[`IACM_CTRL_EN_BIT];
        end
        `IACM_OFS_NHVAL: begin
          state_next.nhValue = regWdata[7:0];
        end
        `IACM_OFS_SRCADDR: begin
          state_next.srcAddr = regWdata;
        end
        `IACM_OFS_SRCMASK: begin
          state_next.srcMask = regWdata;
        end
        `IACM_OFS_ICMPVAL: begin
          state_next.typeValue =
            regWdata[`IACM_ICMP_TYPE_MSB:`IACM_ICMP_TYPE_LSB];
          state_next.codeValue =
            regWdata[`IACM_ICMP_CODE_MSB:`IACM_ICMP_CODE_LSB];
        end
        default: begin
        end
      endcase
    end
    if (regRead) begin
      case (regAddr)
        `IACM_OFS_CTRL: begin
          state_next.rdata = {23'h00_0000, state_reg.entryEn,
            state_reg.codeCare, state_reg.typeCare,
            state_reg.hopMode, state_reg.srcCare,
            state_reg.nhMode};
        end
        `IACM_OFS_NHVAL: begin
          state_next.rdata = {24'h00_0000, state_reg.nhValue};
        end
        `IACM_OFS_SRCADDR: begin
          state_next.rdata = state_reg.srcAddr;
        end
        `IACM_OFS_SRCMASK: begin
          state_next.rdata = state_reg.srcMask;
        end
        `IACM_OFS_ICMPVAL: begin
          state_next.rdata = {16'h0000, state_reg.codeValue,
            state_reg.typeValue};
        end
        `IACM_OFS_STATUS: begin
          state_next.rdata = {30'h0000_0000, state_reg.seenFrame,
            state_reg.lastHit};
        end
        `IACM_OFS_HITCNT: begin
          state_next.rdata = {16'h0000, state_reg.hitCount};
        end
        `IACM_OFS_FRMCNT: begin
          state_next.rdata = {16'h0000, state_reg.frameCount};
        end
        default: begin
          state_next.rdata = `IACM_WORD_RST;
        end
      endcase
    end
  end

  // ********************************************
  // registers
  // ********************************************
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_reg.entryEn <= 1'b0;
      state_reg.nhMode <= NH_ANY;
      state_reg.srcCare <= 1'b0;
      state_reg.hopMode <= HOP_ANY;
      state_reg.typeCare <= 1'b0;
      state_reg.codeCare <= 1'b0;
      state_reg.nhValue <= `IACM_BYTE_RST;
      state_reg.srcAddr <= `IACM_WORD_RST;
      state_reg.srcMask <= `IACM_MASK_RST;
      state_reg.typeValue <= `IACM_BYTE_RST;
      state_reg.codeValue <= `IACM_BYTE_RST;
      state_reg.rdata <= `IACM_WORD_RST;
      state_reg.matchValid <= 1'b0;
      state_reg.matchHit <= 1'b0;
      state_reg.lastHit <= 1'b0;
      state_reg.seenFrame <= 1'b0;
      state_reg.hitCount <= `IACM_CNT_RST;
      state_reg.frameCount <= `IACM_CNT_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  assign regRdata = state_reg.rdata;
  assign matchValid = state_reg.matchValid;
  assign matchHit = state_reg.matchHit;

  // ********************************************
  // assertions
  // ********************************************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);

  nh_any_pass_a: assert property (
    frameValid && frameIsIpv6 && state_reg.entryEn
    && state_reg.nhMode == NH_ANY && !state_reg.srcCare
    && state_reg.hopMode == HOP_ANY && !state_reg.typeCare
    && !state_reg.codeCare
    |=> matchValid && matchHit)
    else $error("don't-care entry missed an ipv6 frame");

  nh_specific_miss_a: assert property (
    frameValid && state_reg.nhMode == NH_SPECIFIC
    && frameNextHdr != state_reg.nhValue
    |=> matchValid && !matchHit)
    else $error("next header mismatch gave a hit");

  nh_proto_sel_a: assert property (
    frameValid && state_reg.nhMode == NH_TCP
    && frameNextHdr != `IACM_PROTO_TCP
    |=> !matchHit)
    else $error("tcp selection hit a non-tcp frame");

  src_masked_a: assert property (
    frameValid && state_reg.srcCare
    && ((frameSrcLow ^ state_reg.srcAddr) & state_reg.srcMask)
       != 32'h0000_0000
    |=> !matchHit)
    else $error("masked source mismatch gave a hit");

  src_mask_dc_a: assert property (
    matchHit && $past(state_reg.srcCare)
    |-> (($past(frameSrcLow) ^ $past(state_reg.srcAddr))
         & $past(state_reg.srcMask)) == 32'h0000_0000)
    else $error("hit with source outside the mask");

  hop_zero_a: assert property (
    frameValid && state_reg.hopMode == HOP_ZERO
    && frameHopLimit != 8'h00
    |=> !matchHit)
    else $error("zero hop setting hit a non-zero hop limit");

  hop_nonzero_a: assert property (
    frameValid && state_reg.hopMode == HOP_NONZERO
    && frameHopLimit == 8'h00
    |=> !matchHit)
    else $error("non-zero hop setting hit a zero hop limit");

  icmp_type_a: assert property (
    frameValid && state_reg.typeCare
    && frameIcmpType != state_reg.typeValue
    |=> !matchHit)
    else $error("icmp type mismatch gave a hit");

  icmp_code_a: assert property (
    frameValid && state_reg.codeCare
    && frameIcmpCode != state_reg.codeValue
    |=> !matchHit)
    else $error("icmp code mismatch gave a hit");

  icmp_only_a: assert property (
    frameValid && (state_reg.typeCare || state_reg.codeCare)
    && !isIcmp
    |=> !matchHit)
    else $error("icmp criteria hit a non-icmp frame");

  all_and_a: assert property (
    matchHit |-> $past(nhHit && srcHit && hopHit && typeHit
                       && codeHit && frameIsIpv6))
    else $error("hit without every criterion met");

  read_one_cycle_a: assert property (
    !regRead |=> regRdata == 32'h0000_0000)
    else $error("read data stood outside its cycle");

  hit_cover_c: cover property (matchValid && matchHit);
  miss_cover_c: cover property (matchValid && !matchHit);
  icmp_hit_c: cover property (
    frameValid && state_reg.typeCare && state_reg.codeCare
    ##1 matchHit);
  masked_hit_c: cover property (
    frameValid && state_reg.srcCare
    && state_reg.srcMask != 32'hffff_ffff ##1 matchHit);

endmodule

`default_nettype wire

/* File: core/iacm_cfg.svh */
`ifndef IACM_CFG_SVH
`define IACM_CFG_SVH

// ********************************************
// register offsets (byte addresses)
// ********************************************
`define IACM_ADDR_W 8
`define IACM_OFS_CTRL 8'h00
`define IACM_OFS_NHVAL 8'h04
`define IACM_OFS_SRCADDR 8'h08
`define IACM_OFS_SRCMASK 8'h0c
`define IACM_OFS_ICMPVAL 8'h10
`define IACM_OFS_STATUS 8'h14
`define IACM_OFS_HITCNT 8'h18
`define IACM_OFS_FRMCNT 8'h1c

// ********************************************
// control field positions
// ********************************************
`define IACM_CTRL_NH_LSB 0
`define IACM_CTRL_NH_MSB 2
`define IACM_CTRL_SRC_BIT 3
`define IACM_CTRL_HOP_LSB 4
`define IACM_CTRL_HOP_MSB 5
`define IACM_CTRL_TYPE_BIT 6
`define IACM_CTRL_CODE_BIT 7
`define IACM_CTRL_EN_BIT 8
`define IACM_ICMP_TYPE_LSB 0
`define IACM_ICMP_TYPE_MSB 7
`define IACM_ICMP_CODE_LSB 8
`define IACM_ICMP_CODE_MSB 15

// ********************************************
// reset values and protocol numbers
// ********************************************
`define IACM_WORD_RST 32'h0000_0000
`define IACM_BYTE_RST 8'h00
`define IACM_MASK_RST 32'hffff_ffff
`define IACM_CNT_W 16
`define IACM_CNT_RST 16'h0000
`define IACM_PROTO_ICMP6 8'h3a
`define IACM_PROTO_UDP 8'h11
`define IACM_PROTO_TCP 8'h06

`endif

/* File: core/iacm_pkg.sv */
`default_nettype none
`include "iacm_cfg.svh"

package iacm_pkg;

  typedef enum logic [2:0] {
    NH_ANY = 3'h0,
    NH_SPECIFIC = 3'h1,
    NH_ICMP = 3'h2,
    NH_UDP = 3'h3,
    NH_TCP = 3'h4
  } iacm_nh_mode_t;

  typedef enum logic [1:0] {
    HOP_ANY = 2'h0,
    HOP_ZERO = 2'h1,
    HOP_NONZERO = 2'h2
  } iacm_hop_mode_t;

  typedef struct packed {
    logic entryEn;
    iacm_nh_mode_t nhMode;
    logic srcCare;
    iacm_hop_mode_t hopMode;
    logic typeCare;
    logic codeCare;
    logic [7:0] nhValue;
    logic [31:0] srcAddr;
    logic [31:0] srcMask;
    logic [7:0] typeValue;
    logic [7:0] codeValue;
    logic [31:0] rdata;
    logic matchValid;
    logic matchHit;
    logic lastHit;
    logic seenFrame;
    logic [`IACM_CNT_W-1:0] hitCount;
    logic [`IACM_CNT_W-1:0] frameCount;
  } iacm_state_t;

endpackage

`default_nettype wire

/* File: core/iacm_field_cmp.sv */
`timescale 1ns/1ps
`default_nettype none

module iacm_field_cmp #(
  parameter int W = 8
) (
  // criterion
  input wire logic care,
  input wire logic [W-1:0] value,
  input wire logic [W-1:0] mask,
  // frame field
  input wire logic [W-1:0] field,
  // result
  output logic hit
);

  // zero mask bits drop out on both sides of the compare
  assign hit = !care || ((field & mask) == (value & mask));

endmodule

`default_nettype wire

/* File: verification/iacm_frame_src.sv */
`timescale 1ns/1ps
`default_nettype none

module iacm_frame_src (
  // clock
  input wire logic ref_clk,
  // parsed header fields
  output logic frameValid,
  output logic frameIsIpv6,
  output logic [7:0] frameNextHdr,
  output logic [31:0] frameSrcLow,
  output logic [7:0] frameHopLimit,
  output logic [7:0] frameIcmpType,
  output logic [7:0] frameIcmpCode
);
  initial begin
    frameValid = 1'b0;
    frameIsIpv6 = 1'b0;
    frameNextHdr = 8'h00;
    frameSrcLow = 32'h0000_0000;
    frameHopLimit = 8'h00;
    frameIcmpType = 8'h00;
    frameIcmpCode = 8'h00;
  end

  // one frame per call; fields go stale (inverted) once valid drops
  task automatic send(input logic v6, input logic [7:0] nh,
      input logic [31:0] sa, input logic [7:0] hl, input logic [7:0] ty,
      input logic [7:0] co);
    @(posedge ref_clk);
    frameValid <= 1'b1;
    frameIsIpv6 <= v6;
    frameNextHdr <= nh;
    frameSrcLow <= sa;
    frameHopLimit <= hl;
    frameIcmpType <= ty;
    frameIcmpCode <= co;
    @(posedge ref_clk);
    frameValid <= 1'b0;
    frameIsIpv6 <= ~v6;
    frameNextHdr <= ~nh;
    frameSrcLow <= ~sa;
    frameHopLimit <= ~hl;
    frameIcmpType <= ~ty;
    frameIcmpCode <= ~co;
  endtask
endmodule

`default_nettype wire

/* File: verification/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "iacm_cfg.svh"

module tb_top;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0000_0000;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [31:0] regRdata;
  logic frameValid, frameIsIpv6;
  logic [7:0] frameNextHdr, frameHopLimit, frameIcmpType, frameIcmpCode;
  logic [31:0] frameSrcLow;
  logic matchValid, matchHit;
  int miscompares = 0;
  int total_checks = 0;
  int cycles = 0;
  int hitCnt = 0;
  int frmCnt = 0;
  logic lastHit = 1'b0;
  logic expQ [$];
  logic [31:0] rngState = 32'h0000_0006;
  logic [31:0] cfg [0:4] = '{32'h0000_0000, 32'h0000_0000,
    32'h0000_0000, 32'hffff_ffff, 32'h0000_0000};
  // writable bits of CTRL, NHVAL, SRCADDR, SRCMASK, ICMPVAL
  logic [31:0] rwMask [0:4] = '{32'h0000_01ff, 32'h0000_00ff,
    32'hffff_ffff, 32'hffff_ffff, 32'h0000_ffff};

  always #50 ref_clk = ~ref_clk;

  iacm_frame_src frameSrc (.ref_clk(ref_clk), .frameValid(frameValid),
    .frameIsIpv6(frameIsIpv6), .frameNextHdr(frameNextHdr),
    .frameSrcLow(frameSrcLow), .frameHopLimit(frameHopLimit),
    .frameIcmpType(frameIcmpType), .frameIcmpCode(frameIcmpCode));

  iacm_matcher dut (.ref_clk(ref_clk), .srst(srst), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .frameValid(frameValid),
    .frameIsIpv6(frameIsIpv6), .frameNextHdr(frameNextHdr),
    .frameSrcLow(frameSrcLow), .frameHopLimit(frameHopLimit),
    .frameIcmpType(frameIcmpType), .frameIcmpCode(frameIcmpCode),
    .matchValid(matchValid), .matchHit(matchHit));

  // ********************************************
  // helpers
  // ********************************************
  function automatic logic [31:0] xs();
    rngState ^= rngState << 13;
    rngState ^= rngState >> 17;
    rngState ^= rngState << 5;
    return rngState;
  endfunction

  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge ref_clk);
    regWrite <= 1'b0;
    regWdata <= ~d;
    if (a < `IACM_OFS_STATUS) cfg[a[4:2]] = d & rwMask[a[4:2]];
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk);
    regRead <= 1'b0;
    #1;
    chk(regRdata, e);
    chk({30'h0000_0000, matchValid, matchHit}, 32'h0000_0000);
  endtask

  function automatic logic model(input logic v6, input logic [7:0] nh,
      input logic [31:0] sa, input logic [7:0] hl, input logic [7:0] ty,
      input logic [7:0] co);
    logic [31:0] c;
    logic ok;
    c = cfg[0];
    case (c[2:0])
      3'h0: ok = 1'b1;
      3'h1: ok = (nh == cfg[1][7:0]);
      3'h2: ok = (nh == `IACM_PROTO_ICMP6);
      3'h3: ok = (nh == `IACM_PROTO_UDP);
      3'h4: ok = (nh == `IACM_PROTO_TCP);
      default: ok = 1'b0;
    endcase
    case (c[5:4])
      2'h1: ok = ok & (hl == 8'h00);
      2'h2: ok = ok & (hl != 8'h00);
      2'h3: ok = 1'b0;
      default: ok = ok;
    endcase
    if (c[3] && ((sa ^ cfg[2]) & cfg[3]) != 32'h0000_0000) ok = 1'b0;
    if (c[6] && ty != cfg[4][7:0]) ok = 1'b0;
    if (c[7] && co != cfg[4][15:8]) ok = 1'b0;
    if ((c[6] | c[7]) && nh != `IACM_PROTO_ICMP6) ok = 1'b0;
    return ok & c[8] & v6;
  endfunction

  task automatic frame(input logic v6, input logic [7:0] nh,
      input logic [31:0] sa, input logic [7:0] hl, input logic [7:0] ty,
      input logic [7:0] co);
    logic e;
    e = model(v6, nh, sa, hl, ty, co);
    expQ.push_back(e);
    frameSrc.send(v6, nh, sa, hl, ty, co);
    #1;
    chk({31'h0000_0000, matchValid}, 32'h0000_0001);
    chk({31'h0000_0000, matchHit}, {31'h0000_0000, expQ.pop_front()});
    frmCnt++;
    hitCnt += e;
    lastHit = e;
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      test_done();
    end
  end

  // ********************************************
  // main sequence
  // ********************************************
  initial begin
    logic [31:0] d, r, r2;
    logic [7:0] nh;
    repeat (4) @(posedge ref_clk);
    srst <= 1'b0;
    for (int a = 0; a < 9; a++) rd(8'(a * 4), cfg[a % 5] & {32{a < 5}});
    wr(`IACM_OFS_STATUS, 32'hffff_ffff);
    rd(`IACM_OFS_STATUS, 32'h0000_0000);
    wr(8'h24, 32'hffff_ffff);
    rd(8'h24, 32'h0000_0000);
    frame(1'b1, 8'h3a, 32'h0000_0000, 8'h01, 8'h00, 8'h00);
    for (int k = 0; k < 32; k++) begin
      for (int a = 0; a < 5; a++) begin
        d = xs();
        if (a == 0) d = {d[31:9], k % 5 != 4, d[7:6], 2'(k >> 3), d[3],
          3'(k)};
        wr(8'(a * 4), d);
      end
      for (int a = 0; a < 5; a++) rd(8'(a * 4), cfg[a]);
      for (int f = 0; f < 12; f++) begin
        r = xs();
        r2 = xs();
        case (r[1:0])
          2'h0: nh = cfg[1][7:0];
          2'h1: nh = `IACM_PROTO_ICMP6;
          2'h2: nh = `IACM_PROTO_UDP;
          default: nh = `IACM_PROTO_TCP;
        endcase
        if (r[2] && r[10]) nh = r[15:8];
        frame(r[9:8] != 2'h0, nh,
          r[4] ? cfg[2] ^ (r2 & ~cfg[3]) : r2, r[5] ? 8'h00 : r[23:16],
          r[6] ? cfg[4][7:0] : r[31:24], r[7] ? cfg[4][15:8] : r2[7:0]);
      end
    end
    rd(`IACM_OFS_STATUS, 32'h0000_0002 | 32'(lastHit));
    rd(`IACM_OFS_HITCNT, 32'(hitCnt));
    rd(`IACM_OFS_FRMCNT, 32'(frmCnt));
    wr(`IACM_OFS_HITCNT, 32'h0000_0000);
    rd(`IACM_OFS_HITCNT, 32'h0000_0000);
    // clear and counted frame in one cycle: the count restarts and the frame makes it one
    fork
      wr(`IACM_OFS_FRMCNT, 32'h0000_0000);
      frame(1'b0, 8'h00, 32'h0000_0000, 8'h00, 8'h00, 8'h00);
    join
    rd(`IACM_OFS_FRMCNT, 32'h0000_0001);
    // second reset mid-run must restore defaults
    @(posedge ref_clk);
    srst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    rd(`IACM_OFS_CTRL, 32'h0000_0000);
    rd(`IACM_OFS_SRCMASK, 32'hffff_ffff);
    rd(`IACM_OFS_FRMCNT, 32'h0000_0000);
    test_done();
  end
endmodule

`default_nettype wire
